// [rtl/vic_pkg.sv]
package vic_pkg;
    localparam int          NUM_VEC     = 28;
    localparam logic [15:0] BASE_ADDR   = 16'hFC00;
    localparam logic [15:0] LAST_ADDR   = 16'hFC1F;
    localparam logic [4:0]  OFF_EN0_LO  = 5'h00;
    localparam logic [4:0]  OFF_EN1_LO  = 5'h01;
    localparam logic [4:0]  OFF_EN0_HI  = 5'h02;
    localparam logic [4:0]  OFF_EN1_HI  = 5'h03;
    localparam logic [4:0]  OFF_ORG0    = 5'h04;
    localparam logic [4:0]  OFF_ORG1    = 5'h05;
    localparam logic [4:0]  OFF_VECTOR  = 5'h06;
    localparam logic [4:0]  OFF_ENCOUNT = 5'h07;
    localparam logic [4:0]  OFF_GDIS    = 5'h08;
    localparam logic [4:0]  OFF_GENA    = 5'h09;
    localparam logic [6:0]  VEC_BASE    = 7'h20;
    localparam logic [4:0]  VEC_NONE    = 5'h18;
    localparam logic [27:0] VEC_USED    = 28'hEFF_FFFF;
    localparam int          LOW_W       = 16;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } vic_bus_t;
    typedef struct packed {
        logic       req;
        logic [4:0] vec;
        logic [6:0] addr;
    } vic_irq_t;
endpackage

// [rtl/vic_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module vic_ctrl
#(
    parameter int CNT_W = 3
)
(
    input  wire logic            sys_clk_in,
    input  wire logic            sys_rst_in,
    input  wire logic [27:0]     src_req_in,
    input  wire vic_pkg::vic_bus_t bus_in,
    output logic [15:0]          rdata_out,
    output vic_pkg::vic_irq_t    irq_out,
    input  wire logic            irq_ack_in
);
    if (CNT_W != 3)
    begin : g_cnt_chk
        $error("enable counter must be 3 bits");
    end

    ////////////////////////////////////////////////////////////////////////
    logic [27:0]      en_lo_q, en_hi_q, org_q;
    logic [4:0]       vec_q;
    logic [CNT_W-1:0] cnt_q;
    logic             hit, wr_gdis, wr_gena, fwd;
    logic [4:0]       off;
    logic [27:0]      wr_org_clr;
    logic             win_ok;
    logic [4:0]       win_vec;
    logic [1:0]       win_lvl;

    assign hit = (bus_in.addr >= vic_pkg::BASE_ADDR) && (bus_in.addr <= vic_pkg::LAST_ADDR);
    assign off = bus_in.addr[4:0];
    assign wr_gdis = bus_in.wr && hit && (off == vic_pkg::OFF_GDIS);
    assign wr_gena = bus_in.wr && hit && (off == vic_pkg::OFF_GENA);

    // Priority level of one vector from its two enable bits.
    function automatic logic [1:0] level(input logic hi, input logic lo);
        level = {hi, lo};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Arbiter: highest level first, then highest vector number.
    always_comb
    begin
        logic [1:0] l;
        l = 2'b00;
        win_ok  = 1'b0;
        win_vec = 5'h00;
        win_lvl = 2'b00;
        for (int i = 0; i < vic_pkg::NUM_VEC; i++)
        begin
            l = level(en_hi_q[i], en_lo_q[i]);
            if (org_q[i] && vic_pkg::VEC_USED[i] && l != 2'b00 && l >= win_lvl)
            begin
                win_ok  = 1'b1;
                win_vec = 5'(i);
                win_lvl = l;
            end
        end
    end

    // Forward only when counter is zero and core is not holding a request.
    assign fwd = win_ok && (cnt_q == '0) && !(irq_out.req && !irq_ack_in);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            en_lo_q <= '0;
            en_hi_q <= '0;
        end
        else if (bus_in.wr && hit)
        begin
            if (off == vic_pkg::OFF_EN0_LO)
                en_lo_q[15:0] <= bus_in.wdata;
            if (off == vic_pkg::OFF_EN1_LO)
                en_lo_q[27:16] <= bus_in.wdata[11:0] & vic_pkg::VEC_USED[27:16];
            if (off == vic_pkg::OFF_EN0_HI)
                en_hi_q[15:0] <= bus_in.wdata;
            if (off == vic_pkg::OFF_EN1_HI)
                en_hi_q[27:16] <= bus_in.wdata[11:0] & vic_pkg::VEC_USED[27:16];
        end
    end

    always_comb
    begin
        wr_org_clr = '0;
        if (bus_in.wr && hit && off == vic_pkg::OFF_ORG0) wr_org_clr[15:0]  = bus_in.wdata;
        if (bus_in.wr && hit && off == vic_pkg::OFF_ORG1) wr_org_clr[27:16] = bus_in.wdata[11:0];
    end

    // Origin flags: a new request wins over a same-cycle clear.
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
            org_q <= '0;
        else
            org_q <= ((org_q & ~wr_org_clr & ~(fwd ? (28'h1 << win_vec) : 28'h0))
                      | src_req_in) & vic_pkg::VEC_USED;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
            cnt_q <= '0;
        else
            cnt_q <= cnt_q + CNT_W'(fwd) + CNT_W'(wr_gdis)
                     - CNT_W'(wr_gena && cnt_q != '0);
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            vec_q   <= '0;
            irq_out <= '0;
        end
        else
        begin
            if (fwd)
            begin
                vec_q        <= win_vec;
                irq_out.req  <= 1'b1;
                irq_out.vec  <= win_vec;
                irq_out.addr <= vic_pkg::VEC_BASE + 7'(win_vec);
            end
            else if (irq_ack_in)
                irq_out.req <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
            rdata_out <= '0;
        else if (bus_in.rd && hit)
        begin
            unique case (off)
                vic_pkg::OFF_EN0_LO:  rdata_out <= en_lo_q[15:0];
                vic_pkg::OFF_EN1_LO:  rdata_out <= {4'h0, en_lo_q[27:16]};
                vic_pkg::OFF_EN0_HI:  rdata_out <= en_hi_q[15:0];
                vic_pkg::OFF_EN1_HI:  rdata_out <= {4'h0, en_hi_q[27:16]};
                vic_pkg::OFF_ORG0:    rdata_out <= org_q[15:0];
                vic_pkg::OFF_ORG1:    rdata_out <= {4'h0, org_q[27:16]};
                vic_pkg::OFF_VECTOR:  rdata_out <= {11'h000, vec_q};
                vic_pkg::OFF_ENCOUNT: rdata_out <= {13'h0000, cnt_q};
                default:              rdata_out <= 16'h0000;
            endcase
        end
        else
            rdata_out <= 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking dflt @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    chk_vec_addr: assert property
        (irq_out.req |-> irq_out.addr == vic_pkg::VEC_BASE + 7'(irq_out.vec))
        else $error("vector address mismatch");

    chk_cnt_block: assert property
        (cnt_q != '0 |-> !fwd)
        else $error("forward while counter nonzero");

    chk_fwd_count: assert property
        (fwd && !wr_gdis && !wr_gena |=> cnt_q == 3'd1)
        else $error("counter not raised by forward");

    chk_gdis_fwd: assert property
        (fwd && wr_gdis |=> cnt_q == 3'd2)
        else $error("disable with forward not two");

    chk_gena_zero: assert property
        (wr_gena && !wr_gdis && cnt_q == '0 && !fwd |=> cnt_q == '0)
        else $error("enable decremented zero");

    chk_no_vec24: assert property
        (irq_out.req |-> irq_out.vec != vic_pkg::VEC_NONE)
        else $error("vector 24 forwarded");

    chk_org_clear: assert property
        (fwd && !src_req_in[win_vec] |=> !org_q[$past(win_vec)])
        else $error("origin not cleared on forward");

    chk_vec_hold: assert property
        (fwd |=> vec_q == $past(win_vec))
        else $error("vector register not updated");

    chk_org_set: assert property
        (src_req_in[0] |=> org_q[0])
        else $error("request lost");

    chk_req_hold: assert property
        (irq_out.req && !irq_ack_in |=> irq_out.req && $stable(irq_out.vec))
        else $error("request dropped before ack");

    chk_req_drop: assert property
        (irq_out.req && irq_ack_in && !fwd |=> !irq_out.req)
        else $error("request kept after ack");

    chk_bit24_inert: assert property
        (!en_lo_q[vic_pkg::VEC_NONE] && !en_hi_q[vic_pkg::VEC_NONE] && !org_q[vic_pkg::VEC_NONE])
        else $error("unused vector bit set");

    chk_vec_range: assert property
        (vec_q < 5'(vic_pkg::NUM_VEC))
        else $error("vector register out of range");

    chk_gdis_step: assert property
        (wr_gdis && !fwd && !wr_gena |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1))
        else $error("disable did not raise counter");

    chk_gena_step: assert property
        (wr_gena && !wr_gdis && cnt_q != '0 |=> cnt_q == CNT_W'($past(cnt_q) - 1'b1))
        else $error("enable did not lower counter");

    chk_rd_idle: assert property
        (!(bus_in.rd && hit) |=> rdata_out == 16'h0000)
        else $error("read data without read");

    chk_fwd_enabled: assert property
        (fwd |-> en_hi_q[win_vec] || en_lo_q[win_vec])
        else $error("disabled source forwarded");

    chk_fwd_pending: assert property
        (fwd |-> org_q[win_vec])
        else $error("forward without origin flag");
endmodule
`default_nettype wire

// [sim/vic_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
module vic_core_model
(
    input  wire logic              sys_clk_in,
    input  wire logic              sys_rst_in,
    input  wire vic_pkg::vic_irq_t irq_in,
    input  wire logic [3:0]        delay_in,
    output logic                   ack_out
);
    logic [3:0] wait_q;
    // The core takes a pending request after a chosen wait and acks it once.
    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in || !irq_in.req || ack_out)
        begin
            wait_q  <= 4'h0;
            ack_out <= 1'b0;
        end
        else if (wait_q == delay_in)
            ack_out <= 1'b1;
        else
            wait_q <= wait_q + 4'h1;
    end
endmodule
`default_nettype wire

// [sim/vic_ctrl_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module vic_ctrl_tb_top;
    logic              sys_clk_in;
    logic              sys_rst_in;
    logic [27:0]       src;
    logic              ack;
    logic [3:0]        dly;
    logic [15:0]       rdata;
    vic_pkg::vic_bus_t bus;
    vic_pkg::vic_irq_t irq;
    int                fail_count = 0;
    int                compares = 0;
    logic [4:0]        order [4] = '{5'h1B, 5'h09, 5'h14, 5'h03};
    vic_ctrl DUT (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .src_req_in(src),
        .bus_in(bus), .rdata_out(rdata), .irq_out(irq), .irq_ack_in(ack));
    vic_core_model core (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .irq_in(irq),
        .delay_in(dly), .ack_out(ack));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] off, input logic [15:0] d);
        @(posedge sys_clk_in) #1;
        bus = '{1'b1, 1'b0, vic_pkg::BASE_ADDR | 16'(off), d};
        @(posedge sys_clk_in) #1;
        bus = '0;
    endtask
    task automatic rd(input logic [4:0] off, input logic [15:0] exp, input string what);
        @(posedge sys_clk_in) #1;
        bus = '{1'b0, 1'b1, vic_pkg::BASE_ADDR | 16'(off), 16'h0000};
        @(posedge sys_clk_in) #1;
        bus = '0;
        check(what, rdata, exp);
    endtask
    task automatic pulse(input logic [27:0] m);
        @(posedge sys_clk_in) #1;
        src = m;
        @(posedge sys_clk_in) #1;
        src = '0;
    endtask
    // Waits for the forwarded request, checks it, then waits for the ack to retire it.
    task automatic wait_irq(input logic [4:0] v);
        int n;
        n = 0;
        while (irq.req !== 1'b1 && n < 20)
        begin
            @(posedge sys_clk_in) #1;
            n++;
        end
        check("irq req", {15'h0000, irq.req}, 16'h0001);
        check("irq vec", {11'h000, irq.vec}, {11'h000, v});
        check("irq addr", {9'h000, irq.addr}, {9'h000, vic_pkg::VEC_BASE + 7'(v)});
        while (irq.req === 1'b1 && n < 40)
        begin
            @(posedge sys_clk_in) #1;
            n++;
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    initial
    begin
        #100000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        sys_rst_in = 1'b1;
        src = '0;
        bus = '0;
        dly = 4'h0;
        repeat (20) @(posedge sys_clk_in);
        #1 sys_rst_in = 1'b0;
        for (int i = 0; i < 8; i++)
            rd(5'(i), 16'h0000, "reset value");
        rd(5'h1F, 16'h0000, "unmapped");
        $display("test reset done");
        wr(5'h00, 16'h0020);
        pulse(28'h000_0020);
        wait_irq(5'h05);
        rd(5'h07, 16'h0001, "count");
        rd(5'h06, 16'h0005, "vector");
        rd(5'h04, 16'h0000, "origin0");
        wr(5'h09, 16'h0000);
        rd(5'h07, 16'h0000, "count");
        wr(5'h09, 16'h0000);
        rd(5'h07, 16'h0000, "count");
        $display("test single done");
        dly = 4'h3;
        wr(5'h08, 16'h0000);
        wr(5'h00, 16'h0208);
        wr(5'h02, 16'h0200);
        wr(5'h01, 16'h0900);
        wr(5'h03, 16'h0810);
        pulse(28'h910_0208);
        rd(5'h05, 16'h0810, "origin1");
        rd(5'h04, 16'h0208, "origin0");
        rd(5'h01, 16'h0800, "enable1 low");
        check("held req", {15'h0000, irq.req}, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            wr(5'h09, 16'h0000);
            wait_irq(order[i]);
        end
        $display("test priority done");
        wr(5'h09, 16'h0000);
        pulse(28'h000_0080);
        rd(5'h04, 16'h0080, "polled origin0");
        check("no req", {15'h0000, irq.req}, 16'h0000);
        wr(5'h04, 16'h0081);
        rd(5'h04, 16'h0000, "cleared origin0");
        $display("test poll done");
        // Disable write lands in the forwarding cycle; the counter must step by two.
        @(posedge sys_clk_in) #1;
        src = 28'h000_0009;
        @(posedge sys_clk_in) #1;
        src = '0;
        bus = '{1'b1, 1'b0, vic_pkg::BASE_ADDR | 16'h0008, 16'h0000};
        @(posedge sys_clk_in) #1;
        bus = '0;
        wait_irq(5'h03);
        rd(5'h07, 16'h0002, "count race");
        rd(5'h04, 16'h0001, "origin0 bit0");
        $display("test race done");
        wrap_up();
    end
endmodule
`default_nettype wire
